/* pwp_controller.sv */
// pwp_controller: protection flags for the third bridge, clear/set registers, write gate
// assumes a 32-bit bus slave with psel/penable phases on the bridge clock
// Functional notes
// [R1] writing zero to any flag bit leaves that flag unchanged
// [R2] writing one to the clear register removes that peripheral's protection
// [R3] clear register at 0x00; event bit1, serial 2-7, timers 8-15, analog 16-19
// [R4] set register at 0x04, same layout, reset value 0x00800000
// [R5] debugger writes pass to the peripheral regardless of protection
// [R6] writing one to the set register protects; reads return protection state
`timescale 1ns/100ps
module pwp_controller
    import pwp_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [31:0]       target_sel,
    input  wire logic              target_write,
    input  wire logic              debug_access,
    output logic                   write_allow,
    output logic                   write_blocked,
    output logic                   event_system_lock,
    output logic [5:0]             serial_unit_lock,
    output logic [7:0]             timer_lock,
    output logic                   adc_lock,
    output logic                   comparator_lock,
    output logic                   dac_lock,
    output logic                   touch_controller_lock
);

    logic [31:0] flags;
    logic [31:0] next_flags;
    logic        hit_clear;
    logic        hit_set;
    logic        wr_access;
    logic        mapped;
    pwp_phase_t  phase;
    pwp_phase_t  next_phase;

    // ==========================================================
    // address decode
    assign hit_clear = (paddr == ADDR_W'(PWP_OFS_CLEAR));  // [R3]
    assign hit_set   = (paddr == ADDR_W'(PWP_OFS_SET));    // [R4]
    assign mapped    = hit_clear | hit_set;
    assign wr_access = psel & penable & pwrite;
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~mapped;

    // ==========================================================
    // bus phase tracking
    // phase names the bus cycle that has just ended
    always_comb
    begin
        next_phase = PWP_PH_IDLE;
        case (phase)
            PWP_PH_IDLE:   next_phase = psel ? PWP_PH_SETUP : PWP_PH_IDLE;
            PWP_PH_SETUP:  next_phase = PWP_PH_ACCESS;
            PWP_PH_ACCESS: next_phase = psel & ~penable ? PWP_PH_SETUP : PWP_PH_IDLE;
            default:       next_phase = PWP_PH_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            phase <= PWP_PH_IDLE;
        else
            phase <= next_phase;
    end

    // ==========================================================
    // protection flags
    // bit 23 stays a read-only one, outside the writable mask
    always_comb
    begin
        next_flags = flags;
        if (wr_access && hit_clear)
            next_flags = flags & ~(pwdata & PWP_FLAG_MASK);  // [R1] [R2]
        else if (wr_access && hit_set)
            next_flags = flags | (pwdata & PWP_FLAG_MASK);   // [R1] [R6]
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            flags <= PWP_RESET_VALUE;  // [R4]
        else
            flags <= next_flags;
    end

    // ==========================================================
    // read data, captured in the setup phase
    // unmapped offsets read back as zero
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
            prdata <= (hit_clear | hit_set) ? flags : 32'h00000000;  // [R6]
    end

    // ==========================================================
    // per-peripheral lock outputs
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            event_system_lock     <= PWP_RESET_VALUE[PWP_BIT_EVENT];
            serial_unit_lock      <= PWP_RESET_VALUE[PWP_BIT_SERIAL +: PWP_NUM_SERIAL];
            timer_lock            <= PWP_RESET_VALUE[PWP_BIT_TIMER +: PWP_NUM_TIMER];
            adc_lock              <= PWP_RESET_VALUE[PWP_BIT_ADC];
            comparator_lock       <= PWP_RESET_VALUE[PWP_BIT_COMP];
            dac_lock              <= PWP_RESET_VALUE[PWP_BIT_DAC];
            touch_controller_lock <= PWP_RESET_VALUE[PWP_BIT_TOUCH];
        end
        else
        begin
            event_system_lock     <= next_flags[PWP_BIT_EVENT];  // [R3]
            serial_unit_lock      <= next_flags[PWP_BIT_SERIAL +: PWP_NUM_SERIAL];
            timer_lock            <= next_flags[PWP_BIT_TIMER +: PWP_NUM_TIMER];
            adc_lock              <= next_flags[PWP_BIT_ADC];
            comparator_lock       <= next_flags[PWP_BIT_COMP];
            dac_lock              <= next_flags[PWP_BIT_DAC];
            touch_controller_lock <= next_flags[PWP_BIT_TOUCH];
        end
    end

    // ==========================================================
    // write gate toward the bridged peripherals
    pwp_write_gate #(
        .WIDTH         (32)
    ) u_gate (
        .target_sel    (target_sel),
        .target_write  (target_write),
        .debug_access  (debug_access),
        .protect       (flags & PWP_FLAG_MASK),
        .write_allow   (write_allow),
        .write_blocked (write_blocked)
    );  // [R5]

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_zero_keeps: assert property ( // [R1]
        wr_access && mapped |=> ((flags ^ $past(flags)) & ~$past(pwdata)) == 32'h00000000)
        else $error("flag changed under a zero write bit");

    chk_clear_ones: assert property ( // [R2]
        wr_access && hit_clear |=> (flags & $past(pwdata) & PWP_FLAG_MASK) == 32'h00000000)
        else $error("clear write left a flag set");

    chk_set_ones: assert property ( // [R6]
        wr_access && hit_set |=> (flags & $past(pwdata) & PWP_FLAG_MASK) == ($past(pwdata) & PWP_FLAG_MASK))
        else $error("set write left a flag clear");

    chk_fixed_bits: assert property ( // [R4]
        (flags & ~PWP_FLAG_MASK) == (PWP_RESET_VALUE & ~PWP_FLAG_MASK))
        else $error("non-flag bits moved from reset value");

    chk_read_state: assert property ( // [R6]
        psel && !penable && !pwrite && mapped |=> prdata == $past(flags))
        else $error("read did not return protection state");

    chk_lock_layout: assert property ( // [R3]
        ##1 timer_lock == flags[PWP_BIT_TIMER +: PWP_NUM_TIMER] && touch_controller_lock == flags[PWP_BIT_TOUCH]
            && event_system_lock == flags[PWP_BIT_EVENT])
        else $error("lock outputs out of step with flags");

    chk_debug_pass: assert property ( // [R5]
        target_write && debug_access |-> write_allow && !write_blocked)
        else $error("debugger write was blocked");

    chk_block_prot: assert property ( // [R5]
        target_write && !debug_access && |(target_sel & flags & PWP_FLAG_MASK) |-> !write_allow)
        else $error("protected write passed");

    chk_unmapped_err: assert property ( // [R3]
        psel && penable && !mapped |-> pslverr ##1 flags == $past(flags))
        else $error("unmapped access not refused");

    chk_phase_order: assert property ( // [R3]
        psel && penable |-> phase == PWP_PH_SETUP)
        else $error("access phase without a setup phase");

    chk_reset_value: assert property ( // [R4]
        @(posedge mclk) disable iff (1'b0)
        sys_rst |=> flags == PWP_RESET_VALUE && !adc_lock && timer_lock == 8'h00 && !event_system_lock)
        else $error("reset did not restore protection state");

    // lock ports mirror the flag store bit for bit
    chk_lock_analog: assert property ( // [R3]
        serial_unit_lock == flags[PWP_BIT_SERIAL +: PWP_NUM_SERIAL] && adc_lock == flags[PWP_BIT_ADC]
            && comparator_lock == flags[PWP_BIT_COMP] && dac_lock == flags[PWP_BIT_DAC])
        else $error("analog or serial lock out of step with flags");

    chk_unmapped_read: assert property ( // [R3]
        psel && !penable && !pwrite && !mapped |=> prdata == 32'h00000000)
        else $error("unmapped read returned nonzero data");

    chk_gate_open: assert property ( // [R5]
        target_write && !(|(target_sel & flags & PWP_FLAG_MASK)) |-> write_allow && !write_blocked)
        else $error("unprotected write was blocked");

    cov_clear: cover property (wr_access && hit_clear && pwdata[PWP_BIT_ADC]);
    cov_set: cover property (wr_access && hit_set ##1 psel && !penable && !pwrite && hit_set);
    cov_blocked: cover property (write_blocked);
    cov_unmapped: cover property (pslverr && !pwrite);
    cov_debug: cover property (target_write && debug_access && |(target_sel & flags));

endmodule

/* pwp_cpu_model.sv */
// pwp_cpu_model: processor side of the register bus, issues word reads and writes
// assumes zero-wait slave, signals change just after the rising edge
`timescale 1ns/100ps
module pwp_cpu_model
(
    input  wire logic       mclk,
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic [7:0]      paddr,
    output logic [31:0]     pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic       pready,
    input  wire logic       pslverr
);
    // ==========================================================
    // bus cycles
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

/* pwp_pkg.sv */
// pwp_pkg: offsets, flag layout and reset values of the peripheral write protect block
// assumes a 32-bit peripheral bus with byte addresses
package pwp_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0]  PWP_OFS_CLEAR   = 8'h00;
    localparam logic [7:0]  PWP_OFS_SET     = 8'h04;

    // ==========================================================
    // reset value and writable flags
    localparam logic [31:0] PWP_RESET_VALUE = 32'h00800000;
    localparam logic [31:0] PWP_FLAG_MASK   = 32'h000ffffe;

    // ==========================================================
    // flag positions
    localparam int PWP_BIT_EVENT  = 1;
    localparam int PWP_BIT_SERIAL = 2;
    localparam int PWP_NUM_SERIAL = 6;
    localparam int PWP_BIT_TIMER  = 8;
    localparam int PWP_NUM_TIMER  = 8;
    localparam int PWP_BIT_ADC    = 16;
    localparam int PWP_BIT_COMP   = 17;
    localparam int PWP_BIT_DAC    = 18;
    localparam int PWP_BIT_TOUCH  = 19;

    // ==========================================================
    // bus access phases
    typedef enum logic [2:0]
    {
        PWP_PH_IDLE   = 3'b001,
        PWP_PH_SETUP  = 3'b010,
        PWP_PH_ACCESS = 3'b100
    } pwp_phase_t;

endpackage

/* pwp_write_gate.sv */
// pwp_write_gate: decides whether a write to a bridged peripheral may proceed
// assumes a one-hot target select laid out like the protection flags
`timescale 1ns/100ps
module pwp_write_gate
    import pwp_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    input  wire logic [WIDTH-1:0] target_sel,
    input  wire logic             target_write,
    input  wire logic             debug_access,
    input  wire logic [WIDTH-1:0] protect,
    output logic                  write_allow,
    output logic                  write_blocked
);

    logic hit;

    // ==========================================================
    // gating
    assign hit           = |(target_sel & protect);
    assign write_allow   = target_write & (debug_access | ~hit);  // [R5]
    assign write_blocked = target_write & ~debug_access & hit;

endmodule

/* testbench.sv */
// testbench: register access, flag layout and write gate checks
// assumes the cpu model as bus master
`timescale 1ns/100ps
module testbench;
    import pwp_pkg::*;
    logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, target_write, debug_access;
    logic write_allow, write_blocked, event_system_lock, adc_lock, comparator_lock, dac_lock;
    logic touch_controller_lock;
    logic [5:0] serial_unit_lock;
    logic [7:0] timer_lock, paddr;
    logic [31:0] pwdata, prdata, target_sel, rd, exp_flags;
    logic err;
    int error_cnt = 0;
    int checks_done = 0;

    pwp_cpu_model cpu (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    pwp_controller DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .target_sel(target_sel), .target_write(target_write), .debug_access(debug_access),
        .write_allow(write_allow), .write_blocked(write_blocked), .event_system_lock(event_system_lock),
        .serial_unit_lock(serial_unit_lock), .timer_lock(timer_lock), .adc_lock(adc_lock),
        .comparator_lock(comparator_lock), .dac_lock(dac_lock),
        .touch_controller_lock(touch_controller_lock));

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic gate(input int b, input logic dbg, input logic [1:0] exp);
        @(posedge mclk);
        target_sel <= 32'h00000001 << b;
        debug_access <= dbg;
        target_write <= 1'b1;
        @(negedge mclk);
        chk({30'h0, write_allow, write_blocked}, {30'h0, exp});
    endtask

    // ==========================================================
    // clock, reset, watchdog
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial
    begin
        repeat (2000) @(posedge mclk);
        error_cnt++;
        complete_run();
    end

    // ==========================================================
    // tests
    initial
    begin
        sys_rst = 1'b1;
        target_sel = 32'h00000000;
        target_write = 1'b0;
        debug_access = 1'b0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        cpu.xfer(1'b0, PWP_OFS_CLEAR, 32'h0, rd, err);
        chk(rd, PWP_RESET_VALUE);
        cpu.xfer(1'b0, PWP_OFS_SET, 32'h0, rd, err);
        chk(rd, PWP_RESET_VALUE);
        exp_flags = PWP_RESET_VALUE | PWP_FLAG_MASK;
        cpu.xfer(1'b1, PWP_OFS_SET, 32'hffffffff, rd, err);
        cpu.xfer(1'b0, PWP_OFS_CLEAR, 32'h0, rd, err);
        chk(rd, exp_flags);
        chk({12'h000, touch_controller_lock, dac_lock, comparator_lock, adc_lock, timer_lock,
             serial_unit_lock, event_system_lock, 1'b0}, PWP_FLAG_MASK);
        cpu.xfer(1'b1, PWP_OFS_CLEAR, 32'h0, rd, err);
        cpu.xfer(1'b1, PWP_OFS_SET, 32'h0, rd, err);
        cpu.xfer(1'b0, PWP_OFS_SET, 32'h0, rd, err);
        chk(rd, exp_flags);
        for (int b = 1; b <= PWP_BIT_TOUCH; b += 6)
        begin
            cpu.xfer(1'b1, PWP_OFS_CLEAR, 32'h00000001 << b, rd, err);
            exp_flags[b] = 1'b0;
            cpu.xfer(1'b0, PWP_OFS_SET, 32'h0, rd, err);
            chk(rd, exp_flags);
        end
        gate(PWP_BIT_TIMER + 1, 1'b0, 2'b01);
        gate(PWP_BIT_TIMER + 1, 1'b1, 2'b10);
        gate(PWP_BIT_TIMER + 5, 1'b0, 2'b10);
        cpu.xfer(1'b1, 8'h08, 32'hffffffff, rd, err);
        chk({31'h0, err}, 32'h00000001);
        cpu.xfer(1'b0, PWP_OFS_CLEAR, 32'h0, rd, err);
        chk(rd, exp_flags);
        chk({31'h0, err}, 32'h00000000);
        cpu.xfer(1'b0, 8'h08, 32'h0, rd, err);
        chk(rd, 32'h00000000);
        chk({31'h0, err}, 32'h00000001);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        chk({12'h000, touch_controller_lock, dac_lock, comparator_lock, adc_lock, timer_lock,
             serial_unit_lock, event_system_lock, 1'b0}, 32'h00000000);
        cpu.xfer(1'b0, PWP_OFS_SET, 32'h0, rd, err);
        chk(rd, PWP_RESET_VALUE);
        complete_run();
    end
endmodule
